// File: inc/seq_params.svh
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// Block geometry
`define SEQ_BLOCK_BYTES 512
`define SEQ_BLOCK_WORDS (`SEQ_BLOCK_BYTES / 4)
`define SEQ_PTR_W 7
`define SEQ_PTR_LAST 7'h7F
`define SEQ_SINGLE_MAX 16'h0002
`define SEQ_CNT_ZERO 16'h0000

// Card command indices
`define SEQ_CMD_STOP 6'h0C
`define SEQ_CMD_RD_SINGLE 6'h11
`define SEQ_CMD_RD_MULTI 6'h12
`define SEQ_CMD_WR_SINGLE 6'h18
`define SEQ_CMD_WR_MULTI 6'h19

// Write mode encodings
`define SEQ_WMODE_PREERASE 32'h0000_0000
`define SEQ_WMODE_OVERWRITE 32'h0000_0001

// Register byte offsets
`define SEQ_REG_CTRL 8'h00
`define SEQ_REG_LBN 8'h04
`define SEQ_REG_CNT 8'h08
`define SEQ_REG_WMODE 8'h0C
`define SEQ_REG_STATUS 8'h10
`define SEQ_REG_IRQ_STAT 8'h14
`define SEQ_REG_IRQ_MASK 8'h18
`define SEQ_REG_DATA 8'h1C

// Control register fields
`define SEQ_CTRL_START 0
`define SEQ_CTRL_STOP 1
`define SEQ_CTRL_OP_LSB 2
`define SEQ_CTRL_OP_MSB 3
`define SEQ_CTRL_SW 4
`define SEQ_CTRL_DMA 5

// Interrupt status bits
`define SEQ_IRQ_DONE 0
`define SEQ_IRQ_BLOCK 1
`define SEQ_IRQ_ERR 2
`define SEQ_IRQ_CARD 3
`define SEQ_IRQ_W 4

`endif

// File: inc/seq_pkg.sv
`include "seq_params.svh"

package seq_pkg;

	// Request kinds as written into the control field
	typedef enum logic [1:0] {
		OP_READ,
		OP_READ_SINGLE,
		OP_WRITE,
		OP_BAD
	} op_t;

	// Completion codes readable after a request
	typedef enum logic [3:0] {
		ERR_NONE,
		ERR_STOP,
		ERR_PARAM,
		ERR_CMD
	} err_t;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CHECK,
		ST_CMD,
		ST_CMD_WAIT,
		ST_RD_DATA,
		ST_RD_DRAIN,
		ST_WR_FILL,
		ST_WR_DATA,
		ST_STOP_CMD,
		ST_STOP_WAIT,
		ST_DONE
	} state_t;

	// Whole state of the sequencer
	typedef struct packed {
		state_t state;
		op_t op;
		logic sw;
		logic dma;
		logic multi;
		logic [31:0] lbn;
		logic [15:0] cnt;
		logic [31:0] wmode;
		logic [31:0] cur_lbn;
		logic [15:0] left;
		logic [15:0] done_cnt;
		logic [`SEQ_PTR_W-1:0] ptr;
		logic primed;
		logic stop_req;
		err_t err;
		logic [`SEQ_IRQ_W-1:0] irq_stat;
		logic [`SEQ_IRQ_W-1:0] irq_mask;
		logic [1:0] ph;
		logic ack;
		logic [31:0] dat;
		logic cd_s1;
		logic cd_s2;
		logic cd_prev;
		logic cmd_req;
		logic [5:0] cmd_idx;
		logic [31:0] cmd_arg;
	} seq_state_t;

endpackage : seq_pkg

// File: rtl/block_buffer_ram.sv
`timescale 1ns/1ps

// One block of word storage with a registered read port
module block_buffer_ram #(
	parameter int W = 32,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [W-1:0] rdata_o
);

	// Storage and read register
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0] q;
	} ram_state_t;

	ram_state_t r_reg, r_next;

	// Write port and read register update
	always_comb begin
		r_next = r_reg;
		if (we_i) begin
			r_next.mem[waddr_i] = wdata_i;
		end
		r_next.q = r_reg.mem[raddr_i];
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rdata_o = r_reg.q;

endmodule : block_buffer_ram

// File: rtl/sd_block_sequencer.sv
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "seq_params.svh"

module sd_block_sequencer
	import seq_pkg::*;
#(
	parameter int ADR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic card_removed_i,
	output logic cmd_req_o,
	output logic [5:0] cmd_index_o,
	output logic [31:0] cmd_arg_o,
	input wire logic cmd_done_i,
	input wire logic cmd_err_i,
	input wire logic rd_valid_i,
	input wire logic [31:0] rd_data_i,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [31:0] wr_data_o,
	output logic preerase_o,
	output logic cd_irq_mask_o
);

	seq_state_t s_reg, s_next; // Whole state and its next value
	logic ram_we; // Buffer write strobe
	logic [31:0] ram_wdata; // Buffer write data
	logic [31:0] ram_q; // Buffer read data, registered
	logic acc; // Bus access being served this cycle
	logic acc_wr; // Bus write being served
	logic [7:0] adr; // Byte offset of the access
	logic stop_set; // Bus asks for a forced stop
	logic block_end; // Current block fully moved
	logic busy; // A request is in progress
	logic xfer; // Data phase of a request

	// Command picked from request kind and block count
	function automatic logic [5:0] cmd_for(input op_t op, input logic multi);
		if (op == OP_WRITE) begin
			return multi ? `SEQ_CMD_WR_MULTI : `SEQ_CMD_WR_SINGLE;
		end
		return multi ? `SEQ_CMD_RD_MULTI : `SEQ_CMD_RD_SINGLE;
	endfunction : cmd_for

	// Byte-lane merge of a bus write
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// One block of buffer between bus and card
	block_buffer_ram #(
		.W(32),
		.DEPTH(`SEQ_BLOCK_WORDS),
		.AW(`SEQ_PTR_W)
	) u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(ram_we),
		.waddr_i(s_reg.ptr),
		.wdata_i(ram_wdata),
		.raddr_i(s_reg.ptr),
		.rdata_o(ram_q)
	);

	assign busy = (s_reg.state != ST_IDLE);
	assign xfer = (s_reg.state == ST_RD_DATA) || (s_reg.state == ST_RD_DRAIN) ||
		(s_reg.state == ST_WR_FILL) || (s_reg.state == ST_WR_DATA);

	// Next-state logic for bus, registers and sequencer
	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		ram_we = 1'b0;
		ram_wdata = rd_data_i;
		stop_set = 1'b0;
		block_end = 1'b0;
		adr = 8'(wb_adr_i);
		acc = (s_reg.ph == 2'h1);
		acc_wr = acc && wb_we_i;

		// Two-flop synchroniser on the removal pin, then change detect
		s_next.cd_s1 = card_removed_i;
		s_next.cd_s2 = s_reg.cd_s1;
		s_next.cd_prev = s_reg.cd_s2;

		// Bus phase: request seen, served, acknowledged
		unique case (s_reg.ph)
			2'h0: begin
				if (wb_cyc_i && wb_stb_i) begin
					s_next.ph = 2'h1;
				end
			end
			2'h1: begin
				s_next.ph = 2'h2;
				s_next.ack = 1'b1;
			end
			default: begin
				s_next.ph = 2'h0;
			end
		endcase

		// Register writes
		if (acc_wr) begin
			unique case (adr)
				`SEQ_REG_CTRL: begin
					if (wb_sel_i[0] && wb_dat_i[`SEQ_CTRL_STOP]) begin
						stop_set = 1'b1;
					end
					if (wb_sel_i[0] && wb_dat_i[`SEQ_CTRL_START] && !busy) begin
						s_next.op = op_t'(wb_dat_i[`SEQ_CTRL_OP_MSB:`SEQ_CTRL_OP_LSB]);
						s_next.sw = wb_dat_i[`SEQ_CTRL_SW];
						s_next.dma = wb_dat_i[`SEQ_CTRL_DMA];
						s_next.cur_lbn = s_reg.lbn;
						s_next.left = s_reg.cnt;
						s_next.done_cnt = `SEQ_CNT_ZERO;
						s_next.err = ERR_NONE;
						s_next.state = ST_CHECK;
					end
				end
				`SEQ_REG_LBN: s_next.lbn = merge(s_reg.lbn, wb_dat_i, wb_sel_i);
				`SEQ_REG_CNT: s_next.cnt = 16'(merge({16'h0000, s_reg.cnt}, wb_dat_i, wb_sel_i));
				`SEQ_REG_WMODE: s_next.wmode = merge(s_reg.wmode, wb_dat_i, wb_sel_i);
				`SEQ_REG_IRQ_STAT: begin
					if (wb_sel_i[0]) begin
						s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[`SEQ_IRQ_W-1:0];
					end
				end
				`SEQ_REG_IRQ_MASK: begin
					if (wb_sel_i[0]) begin
						s_next.irq_mask = wb_dat_i[`SEQ_IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads, captured into the data flop
		if (acc && !wb_we_i) begin
			unique case (adr)
				`SEQ_REG_CTRL: s_next.dat = {26'h0, s_reg.dma, s_reg.sw, s_reg.op, 2'h0};
				`SEQ_REG_LBN: s_next.dat = s_reg.lbn;
				`SEQ_REG_CNT: s_next.dat = {16'h0000, s_reg.cnt};
				`SEQ_REG_WMODE: s_next.dat = s_reg.wmode;
				`SEQ_REG_STATUS: s_next.dat = {s_reg.done_cnt, 8'h00, s_reg.err, 2'h0,
					s_reg.stop_req, busy};
				`SEQ_REG_IRQ_STAT: s_next.dat = {28'h0, s_reg.irq_stat};
				`SEQ_REG_IRQ_MASK: s_next.dat = {28'h0, s_reg.irq_mask};
				`SEQ_REG_DATA: s_next.dat = ram_q;
				default: s_next.dat = 32'h0000_0000;
			endcase
		end

		// Card change event, dropped while a DMA request without the sw flag is in its data phase
		if ((s_reg.cd_s2 != s_reg.cd_prev) && !cd_irq_mask_o) begin
			s_next.irq_stat[`SEQ_IRQ_CARD] = 1'b1;
		end

		// Sequencer
		unique case (s_reg.state)
			ST_IDLE: begin
			end
			ST_CHECK: begin
				if (s_reg.cd_s2) begin
					s_next.err = ERR_STOP;
					s_next.state = ST_DONE;
				end else if (s_reg.stop_req) begin
					s_next.stop_req = 1'b0;
					s_next.err = ERR_STOP;
					s_next.state = ST_DONE;
				end else if ((s_reg.left == `SEQ_CNT_ZERO) || (s_reg.op == OP_BAD) ||
						((s_reg.op == OP_WRITE) &&
						(s_reg.wmode != `SEQ_WMODE_PREERASE) &&
						(s_reg.wmode != `SEQ_WMODE_OVERWRITE))) begin
					s_next.err = ERR_PARAM;
					s_next.state = ST_DONE;
				end else begin
					if (s_reg.op == OP_READ_SINGLE) begin
						s_next.sw = 1'b1;
					end
					s_next.multi = (s_reg.op != OP_READ_SINGLE) &&
						(s_reg.left > `SEQ_SINGLE_MAX);
					s_next.state = ST_CMD;
				end
			end
			ST_CMD: begin
				if (s_reg.stop_req) begin
					// Between single-block commands no card transfer is open
					s_next.stop_req = 1'b0;
					s_next.err = ERR_STOP;
					s_next.state = ST_DONE;
				end else begin
					s_next.cmd_req = 1'b1;
					s_next.cmd_idx = cmd_for(s_reg.op, s_reg.multi);
					s_next.cmd_arg = s_reg.cur_lbn;
					s_next.state = ST_CMD_WAIT;
				end
			end
			ST_CMD_WAIT: begin
				if (cmd_done_i) begin
					s_next.cmd_req = 1'b0;
					s_next.ptr = '0;
					s_next.primed = 1'b0;
					if (cmd_err_i) begin
						s_next.err = ERR_CMD;
						s_next.state = ST_DONE;
					end else if (s_reg.op == OP_WRITE) begin
						s_next.state = ST_WR_FILL;
					end else begin
						s_next.state = ST_RD_DATA;
					end
				end
			end
			ST_RD_DATA: begin
				// Card words fill the block buffer
				if (rd_valid_i) begin
					ram_we = 1'b1;
					s_next.ptr = s_reg.ptr + `SEQ_PTR_W'(1);
					if (s_reg.ptr == `SEQ_PTR_LAST) begin
						s_next.state = ST_RD_DRAIN;
					end
				end
			end
			ST_RD_DRAIN: begin
				// Software reads the block out of the data window
				if (acc && !wb_we_i && (adr == `SEQ_REG_DATA)) begin
					s_next.ptr = s_reg.ptr + `SEQ_PTR_W'(1);
					block_end = (s_reg.ptr == `SEQ_PTR_LAST);
				end
			end
			ST_WR_FILL: begin
				// Software writes the block into the data window
				if (acc_wr && (adr == `SEQ_REG_DATA)) begin
					ram_we = 1'b1;
					ram_wdata = wb_dat_i;
					s_next.ptr = s_reg.ptr + `SEQ_PTR_W'(1);
					if (s_reg.ptr == `SEQ_PTR_LAST) begin
						s_next.state = ST_WR_DATA;
					end
				end
			end
			ST_WR_DATA: begin
				// Buffer words stream to the card; one idle cycle per word
				if (wr_valid_o && wr_ready_i) begin
					s_next.ptr = s_reg.ptr + `SEQ_PTR_W'(1);
					s_next.primed = 1'b0;
					block_end = (s_reg.ptr == `SEQ_PTR_LAST);
				end else begin
					s_next.primed = 1'b1;
				end
			end
			ST_STOP_CMD: begin
				s_next.cmd_req = 1'b1;
				s_next.cmd_idx = `SEQ_CMD_STOP;
				s_next.cmd_arg = 32'h0000_0000;
				s_next.state = ST_STOP_WAIT;
			end
			ST_STOP_WAIT: begin
				if (cmd_done_i) begin
					s_next.cmd_req = 1'b0;
					if (cmd_err_i && (s_reg.err == ERR_NONE)) begin
						s_next.err = ERR_CMD;
					end
					s_next.state = ST_DONE;
				end
			end
			ST_DONE: begin
				s_next.irq_stat[`SEQ_IRQ_DONE] = 1'b1;
				if (s_reg.err != ERR_NONE) begin
					s_next.irq_stat[`SEQ_IRQ_ERR] = 1'b1;
				end
				s_next.state = ST_IDLE;
			end
			default: begin
				s_next.state = ST_IDLE;
			end
		endcase

		// End of a block: advance to the next consecutive block
		if (block_end) begin
			s_next.left = s_reg.left - 16'h0001;
			s_next.done_cnt = s_reg.done_cnt + 16'h0001;
			s_next.cur_lbn = s_reg.cur_lbn + 32'h0000_0001;
			s_next.ptr = '0;
			if (s_reg.left == 16'h0001) begin
				s_next.state = s_reg.multi ? ST_STOP_CMD : ST_DONE;
			end else if (s_reg.multi) begin
				s_next.state = (s_reg.op == OP_WRITE) ? ST_WR_FILL : ST_RD_DATA;
			end else begin
				s_next.state = ST_CMD;
			end
		end

		// Forced stop while data moves aborts through a stop command
		if (xfer && s_reg.stop_req) begin
			s_next.stop_req = 1'b0;
			s_next.err = ERR_STOP;
			s_next.state = ST_STOP_CMD;
		end

		// Buffer needs software: on entry to a drain or fill phase
		if ((s_next.state != s_reg.state) &&
				((s_next.state == ST_RD_DRAIN) || (s_next.state == ST_WR_FILL))) begin
			s_next.irq_stat[`SEQ_IRQ_BLOCK] = 1'b1;
		end

		// A stop written in the same cycle as a clear still counts
		if (stop_set) begin
			s_next.stop_req = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.dat;
	assign irq_o = |(s_reg.irq_stat & s_reg.irq_mask);
	assign cmd_req_o = s_reg.cmd_req;
	assign cmd_index_o = s_reg.cmd_idx;
	assign cmd_arg_o = s_reg.cmd_arg;
	assign wr_valid_o = (s_reg.state == ST_WR_DATA) && s_reg.primed;
	assign wr_data_o = ram_q;
	assign preerase_o = busy && (s_reg.op == OP_WRITE) &&
		(s_reg.wmode == `SEQ_WMODE_PREERASE);
	assign cd_irq_mask_o = xfer && s_reg.dma && !s_reg.sw;

endmodule : sd_block_sequencer

// File: tb/sd_seq_checker.sv
`timescale 1ns/1ps

// Port checks on bus timing, card commands and the write stream
module sd_seq_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire logic cmd_req_o,
	input wire logic [5:0] cmd_index_o,
	input wire logic [31:0] cmd_arg_o,
	input wire logic cmd_done_i,
	input wire logic wr_valid_o,
	input wire logic wr_ready_i,
	input wire logic [31:0] wr_data_o,
	input wire logic preerase_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Words streamed to the card since the last finished command
	logic [15:0] wcnt;

	// Counts write handshakes, restarts on every command completion
	always_ff @(posedge clk_i) begin
		if (rst_i || cmd_done_i)
			wcnt <= 16'h0000;
		else if (wr_valid_o && wr_ready_i)
			wcnt <= wcnt + 16'h0001;
	end

	a_ack_latency: assert property ($rose(wb_stb_i) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
		else $error("bus ack not two cycles after request");
	a_cmd_hold: assert property (cmd_req_o && !cmd_done_i |=>
		cmd_req_o && $stable(cmd_index_o) && $stable(cmd_arg_o))
		else $error("command request changed before done");
	a_cmd_release: assert property (cmd_req_o && cmd_done_i |=> !cmd_req_o)
		else $error("command request kept after done");
	a_cmd_legal: assert property (cmd_req_o |-> cmd_index_o inside {6'h0C, 6'h11,
		6'h12, 6'h18, 6'h19})
		else $error("illegal command index");
	a_stop_arg: assert property (cmd_req_o && cmd_index_o == 6'h0C |-> cmd_arg_o == 32'h0)
		else $error("stop command with nonzero argument");
	a_preerase_write: assert property (preerase_o && cmd_req_o |->
		cmd_index_o inside {6'h0C, 6'h18, 6'h19})
		else $error("pre-erase level during a read command");
	a_block_words: assert property ($rose(cmd_req_o) |-> wcnt[6:0] == 7'h00)
		else $error("partial block streamed before next command");
	a_wr_spacing: assert property (wr_valid_o && wr_ready_i |=> !wr_valid_o)
		else $error("write words back to back");
	a_wr_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
		else $error("write word dropped before ready");

	// Main scenarios reached
	c_stop: cover property ($rose(cmd_req_o) && cmd_index_o == 6'h0C);
	c_wr: cover property (wr_valid_o && wr_ready_i);
	c_irq: cover property ($rose(irq_o));
endmodule : sd_seq_checker

bind sd_block_sequencer sd_seq_checker u_chk (.clk_i, .rst_i, .wb_stb_i, .wb_ack_o, .irq_o,
	.cmd_req_o, .cmd_index_o, .cmd_arg_o, .cmd_done_i, .wr_valid_o, .wr_ready_i, .wr_data_o,
	.preerase_o);

// File: tb/sd_card_model.sv
`timescale 1ns/1ps

// Card behind the host unit: answers commands, sends read blocks, sinks writes
module sd_card_model (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [5:0] idx_i,
	input wire logic [31:0] arg_i,
	input wire logic fail_i,
	input wire logic more_i,
	output logic done_o,
	output logic err_o,
	output logic rd_valid_o,
	output logic [31:0] rd_data_o,
	output logic wr_ready_o
);
	logic [31:0] blk; // Block being sent
	logic slow; // Alternates prompt and slow answers
	logic [3:0] tick = 4'h0; // Drives a stalling ready pattern

	// One block of 128 words, word index in the low byte
	task automatic send(input logic [31:0] b);
		for (int w = 0; w < 128; w++) begin
			rd_valid_o <= 1'b1;
			rd_data_o <= {b[23:0], w[7:0]};
			@(posedge clk_i);
		end
		rd_valid_o <= 1'b0;
		rd_data_o <= ~rd_data_o;
	endtask : send

	// Write sink stalls now and then
	always @(posedge clk_i) begin
		tick <= tick + 4'h1;
		wr_ready_o <= tick[1] | tick[3];
	end

	// Command answers and read data
	initial begin
		done_o = 1'b0;
		err_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o = 32'h0;
		slow = 1'b0;
		forever begin
			@(posedge clk_i);
			if (req_i && !done_o) begin
				repeat (slow ? 4 : 1) @(posedge clk_i);
				slow = ~slow;
				blk = arg_i;
				done_o <= 1'b1;
				err_o <= fail_i;
				@(posedge clk_i);
				done_o <= 1'b0;
				err_o <= ~err_o;
				if (!fail_i && idx_i inside {6'h11, 6'h12})
					send(blk);
			end else if (more_i) begin
				blk = blk + 32'h1;
				send(blk);
			end
		end
	end
endmodule : sd_card_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "seq_params.svh"

// Self-checking bench for the block sequencer
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic card_removed_i = 1'b0;
	logic wb_ack_o, irq_o, cmd_req_o, wr_valid_o, preerase_o, cd_irq_mask_o;
	logic cmd_done_i, cmd_err_i, rd_valid_i, wr_ready_i;
	logic [5:0] cmd_index_o;
	logic [31:0] wb_dat_o, cmd_arg_o, rd_data_i, wr_data_o, q;
	logic [37:0] cq[$]; // Expected commands
	logic [37:0] wq[$]; // Expected write words
	logic req_q = 1'b0;
	logic more = 1'b0;
	logic fail = 1'b0;
	logic msk = 1'b1;
	logic cev = 1'b0; // Card change event expected in the status of this test
	int failures = 0;
	int total_checks = 0;
	int seed = 32'hF6C1;

	// Clock of 100 ns
	always #50 clk_i = ~clk_i;

	sd_block_sequencer u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .card_removed_i, .cmd_req_o,
		.cmd_index_o, .cmd_arg_o, .cmd_done_i, .cmd_err_i, .rd_valid_i, .rd_data_i,
		.wr_valid_o, .wr_ready_i, .wr_data_o, .preerase_o, .cd_irq_mask_o);

	sd_card_model u_card (.clk_i(clk_i), .req_i(cmd_req_o), .idx_i(cmd_index_o),
		.arg_i(cmd_arg_o), .fail_i(fail), .more_i(more), .done_o(cmd_done_i),
		.err_o(cmd_err_i), .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i),
		.wr_ready_o(wr_ready_i));

	// Count a comparison, report a mismatch
	task automatic chk(input string what, input logic [37:0] e, input logic [37:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Print counts and verdict, end the run
	task automatic stop_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Classic single Wishbone cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		r = wb_dat_o;
		chk("ack", 1'b1, wb_ack_o);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	// Read until the masked bits match
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0, q);
			n++;
		end while ((q & m) !== v && n < 3000);
		chk("poll", v, q & m);
	endtask : poll

	// One request from set-up to completion status
	task automatic run(input logic [1:0] op, input logic [15:0] cnt, input logic [31:0] wm,
			input logic [1:0] ext, input logic [3:0] ee, input logic [15:0] eb, input logic stp);
		logic [31:0] lbn;
		logic mul, wrt;
		int nb;
		lbn = $random(seed);
		wrt = (op == 2'd2);
		mul = (op != 2'd1) && (cnt > `SEQ_SINGLE_MAX);
		nb = (ee == 4'h0) ? cnt : int'(stp);
		if (ee == 4'h0 || ee == 4'h3 || stp) begin
			for (int b = 0; b < ((mul || ee == 4'h3) ? 1 : cnt); b++)
				cq.push_back({wrt ? (mul ? `SEQ_CMD_WR_MULTI : `SEQ_CMD_WR_SINGLE)
					: (mul ? `SEQ_CMD_RD_MULTI : `SEQ_CMD_RD_SINGLE), lbn + b});
			if (mul && ee != 4'h3)
				cq.push_back({`SEQ_CMD_STOP, 32'h0});
		end
		wr(`SEQ_REG_LBN, lbn);
		wr(`SEQ_REG_CNT, {16'h0, cnt});
		wr(`SEQ_REG_WMODE, wm);
		wr(`SEQ_REG_CTRL, {26'h0, ext, op, 2'b01});
		for (int b = 0; b < nb; b++) begin
			poll(`SEQ_REG_IRQ_STAT, 32'h2, 32'h2);
			chk("preerase", wrt && wm == 32'h0, preerase_o);
			chk("cd_mask", ext == 2'b10 && op != 2'd1, cd_irq_mask_o);
			for (int w = 0; w < `SEQ_BLOCK_WORDS; w++) begin
				if (wrt) begin
					q = $random(seed);
					wq.push_back({6'h00, q});
					wr(`SEQ_REG_DATA, q);
				end else begin
					bus(1'b0, `SEQ_REG_DATA, 32'h0, q);
					chk("rdata", {lbn[23:0] + b[23:0], w[7:0]}, q);
				end
			end
			wr(`SEQ_REG_IRQ_STAT, 32'h2);
			if (stp)
				wr(`SEQ_REG_CTRL, 32'h2);
			if (mul && !wrt && !stp && b < cnt - 1) begin
				more <= 1'b1;
				@(posedge clk_i);
				more <= 1'b0;
			end
		end
		poll(`SEQ_REG_STATUS, 32'h1, 32'h0);
		chk("status", {eb, 8'h00, ee, 4'h0}, q);
		bus(1'b0, `SEQ_REG_IRQ_STAT, 32'h0, q);
		chk("irq_stat", {cev, ee != 4'h0, 2'b01}, q[3:0]);
		chk("irq_on", msk, irq_o);
		wr(`SEQ_REG_IRQ_STAT, 32'hF);
		chk("irq_off", 1'b0, irq_o);
		chk("left", 0, cq.size() + wq.size());
		$display("test op %0d cnt %0d ended", op, cnt);
	endtask : run

	// Match issued commands and streamed words to the oldest notes
	always @(posedge clk_i) begin
		req_q <= cmd_req_o;
		if (cmd_req_o && !req_q && !rst_i)
			chk("cmd", cq.size() ? cq.pop_front() : '1, {cmd_index_o, cmd_arg_o});
		if (wr_valid_o && wr_ready_i && !rst_i)
			chk("wdata", wq.size() ? wq.pop_front() : '1, {6'h00, wr_data_o});
	end

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk_i);
		failures++;
		stop_test();
	end

	// Main sequence; requests only after reset, counts within the limit
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		poll(`SEQ_REG_STATUS, 32'hFFFFFFFF, 32'h0);
		poll(8'h20, 32'hFFFFFFFF, 32'h0);
		wr(`SEQ_REG_CNT, 32'hFFFF);
		poll(`SEQ_REG_CNT, 32'hFFFF, 32'hFFFF);
		wr(`SEQ_REG_IRQ_MASK, 32'h1);
		run(2'd0, 16'd2, 32'h0, 2'b10, 4'h0, 16'd2, 1'b0);
		run(2'd0, 16'd3, 32'h0, 2'b00, 4'h0, 16'd3, 1'b0);
		run(2'd1, 16'd3, 32'h0, 2'b10, 4'h0, 16'd3, 1'b0);
		run(2'd2, 16'd2, 32'h0, 2'b10, 4'h0, 16'd2, 1'b0);
		run(2'd2, 16'd3, 32'h1, 2'b01, 4'h0, 16'd3, 1'b0);
		run(2'd2, 16'd1, 32'h2, 2'b00, 4'h2, 16'd0, 1'b0);
		run(2'd0, 16'd0, 32'h0, 2'b00, 4'h2, 16'd0, 1'b0);
		run(2'd3, 16'd1, 32'h0, 2'b00, 4'h2, 16'd0, 1'b0);
		wr(`SEQ_REG_CTRL, 32'h2);
		poll(`SEQ_REG_STATUS, 32'h2, 32'h2);
		run(2'd0, 16'd1, 32'h0, 2'b00, 4'h1, 16'd0, 1'b0);
		card_removed_i <= 1'b1;
		cev = 1'b1;
		repeat (4) @(posedge clk_i);
		run(2'd2, 16'd1, 32'h1, 2'b00, 4'h1, 16'd0, 1'b0);
		card_removed_i <= 1'b0;
		run(2'd0, 16'd3, 32'h0, 2'b00, 4'h1, 16'd1, 1'b1);
		cev = 1'b0;
		fail <= 1'b1;
		run(2'd2, 16'd1, 32'h1, 2'b00, 4'h3, 16'd0, 1'b0);
		fail <= 1'b0;
		run(2'd2, 16'd1, 32'h1, 2'b00, 4'h0, 16'd1, 1'b0);
		msk = 1'b0;
		wr(`SEQ_REG_IRQ_MASK, 32'h0);
		run(2'd1, 16'd1, 32'h0, 2'b00, 4'h0, 16'd1, 1'b0);
		stop_test();
	end
endmodule : tb_top
